/* ucs_cache.sv */
// Unified two-way cache with internal SRAM option and direct RAM access.
// Functional notes
// - 8 Kbyte unified cache, two ways, pseudo-LRU victim choice.
// - Lines are four words; a read miss fetches four consecutive words.
// - Each set keeps 15-bit tags and a 2-bit replacement state.
// - Reset sets every replacement state to 00, nothing valid.
// - First fill goes to way zero, state becomes 01.
// - Fill with state 01 goes to way one, state becomes 11.
// - Miss with state 11 replaces way zero, state becomes 10.
// - Miss with state 10 replaces way one, state becomes 01.
// - Cache enable bit at 0 disables the cache entirely.
// - Mode field selects 0, 4 or 8 Kbyte cache; rest is SRAM.
// - SRAM start address comes from config bits [15:6].
// - Zero in tag bits 31 and 30 flushes the line.
// - Way zero, way one and tag RAM have fixed direct bases.
// - Tag RAM is 256 words; each way is 4 Kbytes.
// - Direct access works whatever mode and enable say.
// - Hardware clears the whole tag RAM after reset.
// - Address bit 26 set bypasses the cache.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module ucs_cache #(
    parameter int SETS = 256
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RESETN,
    input  wire logic        I_CE,
    input  wire logic [7:0]  I_REG_ADDR,
    input  wire logic [31:0] I_REG_WDATA,
    input  wire logic        I_REG_WR,
    input  wire logic        I_REG_RD,
    output logic      [31:0] O_REG_RDATA,
    input  wire logic        I_CORE_REQ,
    input  wire logic        I_CORE_WE,
    input  wire logic [31:0] I_CORE_ADDR,
    input  wire logic [31:0] I_CORE_WDATA,
    output logic             O_CORE_READY,
    output logic      [31:0] O_CORE_RDATA,
    output logic             O_MEM_REQ,
    output logic             O_MEM_WE,
    output logic      [31:0] O_MEM_ADDR,
    output logic      [31:0] O_MEM_WDATA,
    input  wire logic        I_MEM_ACK,
    input  wire logic [31:0] I_MEM_RDATA
);
    logic [31:0]        sys_cfg;
    logic [31:0]        way_zero [SETS*4];
    logic [31:0]        way_one  [SETS*4];
    logic [31:0]        tag_ram  [SETS];
    ucs_pkg::ucs_state_e st;
    ucs_pkg::ucs_req_s  rq;
    logic [7:0]         clr_idx;
    logic [1:0]         cnt;
    logic               fill_way;
    logic [1:0]         fill_cs;

    // Victim way and next state; in 4K mode only way zero caches.
    function automatic logic [2:0] repl(input logic [1:0] cs,
                                        input logic only0);
        if (only0)
            return {1'b0, (cs == ucs_pkg::CS_NONE) ? ucs_pkg::CS_W0 : cs};
        case (cs)
            ucs_pkg::CS_NONE:   return {1'b0, ucs_pkg::CS_W0};
            ucs_pkg::CS_W0:     return {1'b1, ucs_pkg::CS_BOTH};
            ucs_pkg::CS_BOTH:   return {1'b0, ucs_pkg::CS_W0_NEW};
            ucs_pkg::CS_W0_NEW: return {1'b1, ucs_pkg::CS_W0};
            default:            return {1'b0, ucs_pkg::CS_W0};
        endcase
    endfunction

    logic        start;
    logic [7:0]  idx;
    logic [9:0]  wi;
    logic [31:0] entry;
    logic [1:0]  cs;
    logic [1:0]  mode;
    logic        use0;
    logic        use1;
    logic        is_w0;
    logic        is_w1;
    logic        is_tag;
    logic        sram;
    logic        sram_way;
    logic        cacheable;
    logic        hit0;
    logic        hit1;
    logic [2:0]  vic;
    logic [14:0] tag_in;

    always_comb begin
        start  = I_CE && st == ucs_pkg::ST_IDLE && I_CORE_REQ;
        idx    = I_CORE_ADDR[11:4];
        wi     = I_CORE_ADDR[11:2];
        entry  = tag_ram[idx];
        cs     = entry[31:ucs_pkg::CS_LO];
        mode   = sys_cfg[ucs_pkg::CFG_MODE_LO +: 2];
        tag_in = I_CORE_ADDR[ucs_pkg::TAG_LO +: ucs_pkg::TAG_W];
        use0   = sys_cfg[ucs_pkg::CFG_EN_BIT] && mode != ucs_pkg::MODE_0K;
        use1   = sys_cfg[ucs_pkg::CFG_EN_BIT] && mode == ucs_pkg::MODE_8K;
        is_w0  = I_CORE_ADDR[31:23] == ucs_pkg::WAY0_REGION;
        is_w1  = I_CORE_ADDR[31:23] == ucs_pkg::WAY1_REGION;
        is_tag = I_CORE_ADDR[31:23] == ucs_pkg::TAG_REGION;
        // Way one in 4K mode and both ways in 0K mode answer as SRAM at the programmed base.
        sram   = I_CORE_ADDR[31:26] == 6'h00 && I_CORE_ADDR[15:13] == 3'h0
               && I_CORE_ADDR[25:16] == sys_cfg[ucs_pkg::CFG_BASE_LO +: 10]
               && (mode == ucs_pkg::MODE_0K
               || (mode == ucs_pkg::MODE_4K && !I_CORE_ADDR[12]));
        sram_way  = (mode == ucs_pkg::MODE_4K) ? 1'b1 : I_CORE_ADDR[12];
        cacheable = use0 && !sram && !I_CORE_ADDR[ucs_pkg::NC_BIT]
                  && I_CORE_ADDR[31:27] == 5'h00;
        hit0 = cs != ucs_pkg::CS_NONE && entry[14:0] == tag_in;
        hit1 = use1 && cs[1] && entry[29:ucs_pkg::TAG1_LO] == tag_in;
        vic  = repl(cs, !use1);
    end

    // Register port: read data appear in the cycle after the read strobe.
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sys_cfg     <= ucs_pkg::CFG_RESET;
            O_REG_RDATA <= 32'h0000_0000;
        end else if (I_CE) begin
            if (I_REG_WR && I_REG_ADDR == ucs_pkg::REG_CFG)
                sys_cfg <= I_REG_WDATA & ucs_pkg::CFG_MASK;
            if (I_REG_RD) begin
                case (I_REG_ADDR)
                    ucs_pkg::REG_CFG:  O_REG_RDATA <= sys_cfg;
                    ucs_pkg::REG_STAT: O_REG_RDATA <= {30'h0, st};
                    default:           O_REG_RDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Storage arrays; they hold no reset, the tag RAM is cleared by walking.
    always_ff @(posedge I_REF_CLK) begin
        if (I_CE) begin
            if (st == ucs_pkg::ST_CLR)
                tag_ram[clr_idx] <= 32'h0000_0000;
            if (start && I_CORE_WE) begin
                if (is_w0 || (sram && !sram_way))
                    way_zero[wi] <= I_CORE_WDATA;
                if (is_w1 || (sram && sram_way))
                    way_one[wi] <= I_CORE_WDATA;
                if (is_tag)
                    tag_ram[I_CORE_ADDR[9:2]] <= I_CORE_WDATA;
                if (cacheable && hit0)
                    way_zero[wi] <= I_CORE_WDATA;
                if (cacheable && hit1)
                    way_one[wi] <= I_CORE_WDATA;
            end
            if (st == ucs_pkg::ST_FILL && I_MEM_ACK) begin
                if (fill_way)
                    way_one[{rq.addr[11:4], cnt}] <= I_MEM_RDATA;
                else
                    way_zero[{rq.addr[11:4], cnt}] <= I_MEM_RDATA;
                if (cnt == ucs_pkg::LAST_WORD)
                    tag_ram[rq.addr[11:4]] <= fill_way
                        ? {fill_cs, rq.addr[26:12], tag_ram[rq.addr[11:4]][14:0]}
                        : {fill_cs, tag_ram[rq.addr[11:4]][29:15], rq.addr[26:12]};
            end
        end
    end

    // Control sequence, core answers and the external memory port.
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st           <= ucs_pkg::ST_CLR;
            rq           <= '0;
            clr_idx      <= 8'h00;
            cnt          <= 2'h0;
            fill_way     <= 1'b0;
            fill_cs      <= 2'h0;
            O_CORE_READY <= 1'b0;
            O_CORE_RDATA <= 32'h0000_0000;
            O_MEM_REQ    <= 1'b0;
            O_MEM_WE     <= 1'b0;
            O_MEM_ADDR   <= 32'h0000_0000;
            O_MEM_WDATA  <= 32'h0000_0000;
        end else if (I_CE) begin
            O_CORE_READY <= 1'b0;
            case (st)
                ucs_pkg::ST_CLR: begin
                    clr_idx <= clr_idx + 8'h01;
                    if (clr_idx == ucs_pkg::LAST_SET)
                        st <= ucs_pkg::ST_IDLE;
                end
                ucs_pkg::ST_IDLE: begin
                    if (start) begin
                        rq <= '{we: I_CORE_WE, addr: I_CORE_ADDR,
                                wdata: I_CORE_WDATA};
                        if (is_w0 || is_w1 || is_tag || sram) begin
                            O_CORE_READY <= 1'b1;
                            if (is_tag)
                                O_CORE_RDATA <= tag_ram[I_CORE_ADDR[9:2]];
                            else if (is_w0 || (sram && !sram_way))
                                O_CORE_RDATA <= way_zero[wi];
                            else
                                O_CORE_RDATA <= way_one[wi];
                        end else if (cacheable && !I_CORE_WE
                                     && (hit0 || hit1)) begin
                            O_CORE_READY <= 1'b1;
                            O_CORE_RDATA <= hit1 ? way_one[wi]
                                                 : way_zero[wi];
                        end else if (cacheable && !I_CORE_WE) begin
                            st         <= ucs_pkg::ST_FILL;
                            fill_way   <= vic[2];
                            fill_cs    <= vic[1:0];
                            cnt        <= 2'h0;
                            O_MEM_REQ  <= 1'b1;
                            O_MEM_WE   <= 1'b0;
                            O_MEM_ADDR <= {I_CORE_ADDR[31:4], 4'h0};
                        end else begin
                            // Writes go through to memory; no allocation.
                            st          <= ucs_pkg::ST_BYP;
                            O_MEM_REQ   <= 1'b1;
                            O_MEM_WE    <= I_CORE_WE;
                            O_MEM_ADDR  <= I_CORE_ADDR;
                            O_MEM_WDATA <= I_CORE_WDATA;
                        end
                    end
                end
                ucs_pkg::ST_FILL: begin
                    if (I_MEM_ACK) begin
                        cnt        <= cnt + 2'h1;
                        O_MEM_ADDR <= O_MEM_ADDR + 32'h4;
                        if (cnt == rq.addr[3:2])
                            O_CORE_RDATA <= I_MEM_RDATA;
                        if (cnt == ucs_pkg::LAST_WORD) begin
                            st           <= ucs_pkg::ST_IDLE;
                            O_MEM_REQ    <= 1'b0;
                            O_CORE_READY <= 1'b1;
                        end
                    end
                end
                ucs_pkg::ST_BYP: begin
                    if (I_MEM_ACK) begin
                        st           <= ucs_pkg::ST_IDLE;
                        O_MEM_REQ    <= 1'b0;
                        O_MEM_WE     <= 1'b0;
                        O_CORE_READY <= 1'b1;
                        if (!rq.we)
                            O_CORE_RDATA <= I_MEM_RDATA;
                    end
                end
                default: st <= ucs_pkg::ST_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);

    clear_end_a: assert property (
        st == ucs_pkg::ST_CLR && clr_idx == ucs_pkg::LAST_SET && I_CE
        |=> st == ucs_pkg::ST_IDLE && tag_ram[ucs_pkg::LAST_SET] == 32'h0)
        else $error("tag clear did not finish at last set");
    fill_done_a: assert property (
        st == ucs_pkg::ST_FILL && I_MEM_ACK && I_CE
        && cnt == ucs_pkg::LAST_WORD
        |=> O_CORE_READY && !O_MEM_REQ && st == ucs_pkg::ST_IDLE)
        else $error("line fill did not end after four words");
    repl_state_a: assert property (
        start && cacheable && !I_CORE_WE && !hit0 && !hit1 && use1
        && cs == ucs_pkg::CS_BOTH
        |=> st == ucs_pkg::ST_FILL && !fill_way
        && fill_cs == ucs_pkg::CS_W0_NEW)
        else $error("wrong victim for a full set");
    alt_victim_a: assert property (
        start && cacheable && !I_CORE_WE && !hit0 && !hit1 && use1
        && cs == ucs_pkg::CS_W0_NEW
        |=> fill_way && fill_cs == ucs_pkg::CS_W0)
        else $error("way one not chosen after state 10");
    hit_local_a: assert property (
        start && cacheable && !I_CORE_WE && (hit0 || hit1)
        |=> O_CORE_READY && !O_MEM_REQ
        && tag_ram[$past(idx)] == $past(entry))
        else $error("hit touched memory or state");
    second_fill_a: assert property (
        start && cacheable && !I_CORE_WE && !hit0 && !hit1 && use1
        && cs == ucs_pkg::CS_W0
        |=> st == ucs_pkg::ST_FILL && fill_way
        && fill_cs == ucs_pkg::CS_BOTH)
        else $error("second fill did not go to way one");
    flush_miss_a: assert property (
        start && cacheable && !I_CORE_WE && cs == ucs_pkg::CS_NONE
        |=> st == ucs_pkg::ST_FILL)
        else $error("flushed line gave a hit");
    nc_bypass_a: assert property (
        start && I_CORE_ADDR[ucs_pkg::NC_BIT] && I_CORE_ADDR[31:27] == 5'h0
        |=> st == ucs_pkg::ST_BYP && O_MEM_REQ)
        else $error("non-cacheable access not bypassed");
    disabled_a: assert property (
        start && !sys_cfg[ucs_pkg::CFG_EN_BIT]
        |=> st != ucs_pkg::ST_FILL)
        else $error("disabled cache performed a fill");
    direct_a: assert property (
        start && (is_w0 || is_w1 || is_tag)
        |=> O_CORE_READY && st == ucs_pkg::ST_IDLE)
        else $error("direct RAM access not answered in one cycle");

    fill_c: cover property (st == ucs_pkg::ST_FILL ##1 O_CORE_READY);
    hit_c:  cover property (start && cacheable && hit1);
    byp_c:  cover property (st == ucs_pkg::ST_BYP && I_MEM_ACK);
    sram_c: cover property (start && sram);
endmodule // ucs_cache

/* ucs_pkg.sv */
// Constants, types and layouts shared by the unified cache block.
package ucs_pkg;
    // Register offsets on the plain register port.
    localparam logic [7:0]  REG_CFG     = 8'h00;
    localparam logic [7:0]  REG_STAT    = 8'h04;
    localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
    localparam logic [31:0] CFG_MASK    = 32'h0000_fff2;
    localparam int          CFG_EN_BIT  = 1;
    localparam int          CFG_MODE_LO = 4;
    localparam int          CFG_BASE_LO = 6;
    // Cache size select values.
    localparam logic [1:0]  MODE_4K     = 2'h0;
    localparam logic [1:0]  MODE_8K     = 2'h1;
    localparam logic [1:0]  MODE_0K     = 2'h2;
    // Direct access regions, taken from address bits [31:23].
    localparam logic [8:0]  WAY0_REGION = 9'h020;
    localparam logic [8:0]  WAY1_REGION = 9'h021;
    localparam logic [8:0]  TAG_REGION  = 9'h022;
    localparam int          NC_BIT      = 26;
    localparam int          TAG_LO      = 12;
    localparam int          TAG_W       = 15;
    localparam int          TAG1_LO     = 15;
    localparam int          CS_LO       = 30;
    localparam logic [1:0]  LAST_WORD   = 2'h3;
    localparam logic [7:0]  LAST_SET    = 8'hff;
    // Replacement state codes held in tag bits [31:30].
    localparam logic [1:0]  CS_NONE     = 2'h0;
    localparam logic [1:0]  CS_W0       = 2'h1;
    localparam logic [1:0]  CS_W0_NEW   = 2'h2;
    localparam logic [1:0]  CS_BOTH     = 2'h3;

    typedef enum logic [1:0] {
        ST_CLR  = 2'b00,
        ST_IDLE = 2'b01,
        ST_FILL = 2'b10,
        ST_BYP  = 2'b11
    } ucs_state_e;

    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ucs_req_s;
endpackage

/* ucs_mem_model.sv */
// Behavioural external memory that answers fill and bypass requests.
`timescale 1ns/1ps
module ucs_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    input  wire logic [1:0]  i_lat,
    output logic             o_ack,
    output logic      [31:0] o_rdata,
    output int               o_acks
);
    logic [1:0] wait_c;

    // Between answers the data lines toggle, so a stale word never passes.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack   <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_acks  <= 0;
            wait_c  <= 2'h0;
        end else begin
            o_ack   <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_req && !o_ack) begin
                if (wait_c >= i_lat) begin
                    o_ack   <= 1'b1;
                    o_rdata <= {8'h5a, i_addr[25:2]};
                    o_acks  <= o_acks + 1;
                    wait_c  <= 2'h0;
                end else begin
                    wait_c <= wait_c + 2'h1;
                end
            end
        end
    end
endmodule // ucs_mem_model

/* testbench.sv */
// Self-checking bench for the unified cache with a memory model behind it.
`timescale 1ns/1ps
module testbench;
    logic        ref_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr  = 1'b0;
    logic        reg_rd  = 1'b0;
    logic [31:0] reg_rdata;
    logic        core_req = 1'b0;
    logic        core_we = 1'b0;
    logic [31:0] core_addr = 32'h0000_0000;
    logic [31:0] core_wdata = 32'h0000_0000;
    logic        core_ready;
    logic [31:0] core_rdata;
    logic        ce      = 1'b1;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_wdata;
    logic        mem_ack;
    logic [31:0] mem_addr;
    logic [31:0] mem_rdata;
    logic [1:0]  lat = 2'h0;
    int          acks;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    logic [32:0] core_q[$];
    logic [31:0] reg_q[$];
    logic        rd_seen = 1'b0;
    logic [7:0]  set;
    logic [14:0] t1;
    logic [9:0]  base;
    logic [31:0] d;
    logic [31:0] sa;

    ucs_cache #(.SETS(256)) i_ucs_cache (
        .I_REF_CLK(ref_clk), .I_RESETN(resetn), .I_CE(ce),
        .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .I_REG_WR(reg_wr),
        .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata), .I_CORE_REQ(core_req),
        .I_CORE_WE(core_we), .I_CORE_ADDR(core_addr),
        .I_CORE_WDATA(core_wdata), .O_CORE_READY(core_ready),
        .O_CORE_RDATA(core_rdata), .O_MEM_REQ(mem_req), .O_MEM_WE(mem_we),
        .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata), .I_MEM_ACK(mem_ack),
        .I_MEM_RDATA(mem_rdata));
    ucs_mem_model i_ucs_mem_model (
        .i_clk(ref_clk), .i_rst_n(resetn), .i_req(mem_req), .i_addr(mem_addr),
        .i_lat(lat), .o_ack(mem_ack), .o_rdata(mem_rdata), .o_acks(acks));

    always #2.5 ref_clk = ~ref_clk;

    function automatic logic [31:0] ca(input logic [14:0] t,
                                       input logic [1:0]  w);
        return {5'h00, t, set, w, 2'h0};
    endfunction
    function automatic logic [31:0] mw(input logic [31:0] a);
        return {8'h5a, a[25:2]};
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_acc(input logic wr, input logic [7:0] a,
                           input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= v;
        if (!wr) reg_q.push_back(v);
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic core(input logic we, input logic [31:0] a,
                        input logic [31:0] v, input int chk);
        @(posedge ref_clk);
        core_req <= 1'b1;
        core_we <= we;
        core_addr <= a;
        core_wdata <= v;
        lat <= 2'($urandom_range(0, 3));
        core_q.push_back({chk != 0, v});
        @(posedge ref_clk);
        core_req <= 1'b0;
        for (int i = 0; i < 200; i++) begin
            #1;
            if (core_ready === 1'b1) break;
            @(posedge ref_clk);
        end
        #1;
        // A request that never completes is a failure, not a silent skip.
        if (core_ready !== 1'b1) num_errors++;
    endtask
    // An access whose number of external words is known in advance.
    task automatic extv(input logic we, input logic [31:0] a,
                        input logic [31:0] v, input int n);
        int a0;
        a0 = acks;
        core(we, a, v, !we);
        cmp(32'(acks - a0), 32'(n));
    endtask
    task automatic ext(input logic [31:0] a, input int n);
        extv(1'b0, a, mw(a), n);
    endtask
    task automatic tagchk(input logic [31:0] exp);
        core(1'b0, 32'h1100_0000 | {22'h0, set, 2'h0}, exp, 1'b1);
    endtask

    // Read data is looked at only in the cycle after the strobe.
    always @(posedge ref_clk) begin
        rd_seen <= reg_rd;
        if (rd_seen === 1'b1) cmp(reg_rdata, reg_q.pop_front());
        if (core_ready === 1'b1) begin
            if (core_q[0][32]) cmp(core_rdata, core_q[0][31:0]);
            void'(core_q.pop_front());
        end
        if (mem_ack === 1'b1 && mem_we === 1'b1) cmp(mem_wdata, d);
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h5f03));
        set = 8'($urandom);
        t1 = {1'b0, 10'($urandom), 4'h2};
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        reg_acc(1'b0, ucs_pkg::REG_STAT, 32'h0);
        reg_acc(1'b0, ucs_pkg::REG_CFG, ucs_pkg::CFG_RESET);
        reg_acc(1'b0, 8'h08, 32'h0);
        // With the enable low the tag walk must stand still where it is.
        ce <= 1'b0;
        repeat (250) @(posedge ref_clk);
        ce <= 1'b1;
        reg_acc(1'b0, ucs_pkg::REG_STAT, 32'h0);
        repeat (300) @(posedge ref_clk);
        reg_acc(1'b0, ucs_pkg::REG_STAT, 32'h1);
        for (int i = 0; i < 4; i++) begin
            core(1'b0, 32'h1100_0000 | {22'h0, 8'($urandom), 2'h0}, 0, 1);
        end
        reg_acc(1'b1, ucs_pkg::REG_CFG, 32'hffff_ffff);
        reg_acc(1'b0, ucs_pkg::REG_CFG, ucs_pkg::CFG_MASK);
        reg_acc(1'b1, ucs_pkg::REG_CFG, 32'h2 | {ucs_pkg::MODE_8K, 4'h0});
        $display("test reset done");
        ext(ca(t1, 2'h1), 4);
        tagchk({ucs_pkg::CS_W0, 15'h0, t1});
        ext(ca(t1, 2'h3), 0);
        tagchk({ucs_pkg::CS_W0, 15'h0, t1});
        core(1'b0, 32'h1000_0000 | {set, 4'h4}, mw(ca(t1, 2'h1)), 1);
        ext(ca(t1 ^ 15'h0100, 2'h0), 4);
        tagchk({ucs_pkg::CS_BOTH, t1 ^ 15'h0100, t1});
        core(1'b0, 32'h1080_0000 | {set, 4'h0}, mw(ca(t1 ^ 15'h0100, 2'h0)), 1);
        ext(ca(t1 ^ 15'h0200, 2'h2), 4);
        tagchk({ucs_pkg::CS_W0_NEW, t1 ^ 15'h0100, t1 ^ 15'h0200});
        ext(ca(t1 ^ 15'h0400, 2'h1), 4);
        tagchk({ucs_pkg::CS_W0, t1 ^ 15'h0400, t1 ^ 15'h0200});
        // Software clears the entry itself, as after any reconfiguration.
        core(1'b1, 32'h1100_0000 | {22'h0, set, 2'h0}, 32'h0, 0);
        ext(ca(t1 ^ 15'h0400, 2'h1), 4);
        tagchk({ucs_pkg::CS_W0, 15'h0, t1 ^ 15'h0400});
        d = $urandom;
        extv(1'b1, ca(t1 ^ 15'h0400, 2'h2), d, 1);
        extv(1'b0, ca(t1 ^ 15'h0400, 2'h2), d, 0);
        $display("test replace done");
        ext(ca(t1, 2'h1) | 32'h0400_0000, 1);
        ext(ca(t1, 2'h1) | 32'h0400_0000, 1);
        reg_acc(1'b1, ucs_pkg::REG_CFG, {26'h0, ucs_pkg::MODE_8K, 4'h0});
        ext(ca(t1 ^ 15'h0400, 2'h1), 1);
        core(1'b0, 32'h1000_0000 | {set, 4'h4}, mw(ca(t1 ^ 15'h0400, 2'h1)), 1);
        $display("test bypass done");
        base = 10'($urandom);
        reg_acc(1'b1, ucs_pkg::REG_CFG, 32'h2 | {base, ucs_pkg::MODE_0K, 4'h0});
        sa = {6'h0, base, 3'h0, 1'b1, set, 4'h8};
        d = $urandom;
        core(1'b1, sa, d, 0);
        extv(1'b0, sa, d, 0);
        core(1'b0, sa, d, 1);
        core(1'b0, 32'h1080_0000 | {set, 4'h8}, d, 1);
        reg_acc(1'b1, ucs_pkg::REG_CFG, 32'h2 | {base, ucs_pkg::MODE_4K, 4'h0});
        d = $urandom;
        core(1'b1, sa & ~32'h1000, d, 0);
        core(1'b0, sa & ~32'h1000, d, 1);
        core(1'b0, 32'h1080_0000 | {set, 4'h8}, d, 1);
        $display("test sram done");
        repeat (4) @(posedge ref_clk);
        print_verdict();
    end
endmodule // testbench
